// >>> shared/palette_pkg.sv
// shared constants and types for the palette host register port
package palette_pkg;
	// register select codes
	localparam logic [1:0] SEL_SET   = 2'h0;
	localparam logic [1:0] SEL_INDEX = 2'h1;
	localparam logic [1:0] SEL_DATA  = 2'h2;
	// data set codes
	localparam logic [7:0] SET_TRUE_WR  = 8'h00;
	localparam logic [7:0] SET_TRUE_RD  = 8'h01;
	localparam logic [7:0] SET_PSEU_WR  = 8'h02;
	localparam logic [7:0] SET_PSEU_RD  = 8'h03;
	localparam logic [7:0] SET_OVL_WR   = 8'h20;
	localparam logic [7:0] SET_OVL_RD   = 8'h21;
	localparam logic [7:0] SET_PMASK    = 8'h40;
	localparam logic [7:0] SET_OMASK    = 8'h43;
	localparam logic [7:0] SET_DACCTL   = 8'h46;
	localparam logic [7:0] SET_PIXMODE  = 8'h49;
	localparam logic [7:0] SET_PAN      = 8'h4A;
	localparam logic [7:0] SET_COMPOS   = 8'h4B;
	localparam logic [7:0] SET_CSUM_LO  = 8'h80;
	localparam logic [7:0] SET_CSUM_MID = 8'h81;
	localparam logic [7:0] SET_CSUM_HI  = 8'h82;
	// implemented widths of narrow control registers
	localparam logic [7:0] MASK_PMASK   = 8'hFF;
	localparam logic [7:0] MASK_OMASK   = 8'h03;
	localparam logic [7:0] MASK_DACCTL  = 8'h1F;
	localparam logic [7:0] MASK_PIXMODE = 8'h7F;
	localparam logic [7:0] MASK_PAN     = 8'h0F;
	localparam logic [7:0] MASK_COMPOS  = 8'h03;
	localparam logic [7:0] RESET_BYTE   = 8'h00;
	// table sizes
	localparam int TABLE_ENTRIES   = 256;
	localparam int OVERLAY_ENTRIES = 4;
	// colour component counter
	typedef enum logic [1:0] {COMP_RED, COMP_GREEN, COMP_BLUE} comp_type;
	// one 24-bit colour entry
	typedef struct packed {
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
	} colour_type;
	// strobe events after synchronisation
	typedef struct packed {
		logic       wr_fall;
		logic       wr_rise;
		logic       rd_fall;
		logic       rd_rise;
	} strobe_ev_type;
endpackage

// >>> rtl/strobe_sync.sv
// synchroniser and edge detector for the host strobes and selects
`timescale 1ns/1ps
module strobe_sync
	import palette_pkg::*;
(
	input  wire logic          clock,
	input  wire logic          sys_rst,
	input  wire logic          write_strobe_n,
	input  wire logic          read_strobe_n,
	input  wire logic          vsync_n,
	input  wire logic [1:0]    register_select,
	input  wire logic [7:0]    data_in,
	output strobe_ev_type      events,
	output logic [1:0]         select_sync,
	output logic [7:0]         data_sync,
	output logic               vsync_low
);
	logic [2:0] wr_r;
	logic [2:0] rd_r;
	logic [1:0] vs_r;
	logic [1:0] sel1_r;
	logic [7:0] dat1_r;

	// two stages before use; third stage only feeds edge detection
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wr_r <= 3'h7;
			rd_r <= 3'h7;
			vs_r <= 2'h3;
			sel1_r <= 2'h0;
			select_sync <= 2'h0;
			dat1_r <= 8'h00;
			data_sync <= 8'h00;
		end else begin
			wr_r <= {wr_r[1:0], write_strobe_n};
			rd_r <= {rd_r[1:0], read_strobe_n};
			vs_r <= {vs_r[0], vsync_n};
			sel1_r <= register_select;
			select_sync <= sel1_r;
			dat1_r <= data_in;
			data_sync <= dat1_r;
		end
	end

	// edges seen between stage two and stage three
	assign events.wr_fall = wr_r[2] & ~wr_r[1];
	assign events.wr_rise = ~wr_r[2] & wr_r[1];
	assign events.rd_fall = rd_r[2] & ~rd_r[1];
	assign events.rd_rise = ~rd_r[2] & rd_r[1];
	assign vsync_low = ~vs_r[1];
endmodule

// >>> rtl/palette_host_register_port.sv
// host register port: set, index and data registers of the palette
// Functional notes
// - select latched at write strobe fall, data taken at its rise.
// - read latches select at strobe fall, drives bus until rise.
// - latched two select bits choose the targeted host location.
// - one eight-bit two-way data bus, driven only during reads.
// - select 0 set, 1 index, 2 data; code 3 reserved.
// - set is upper and index lower byte of a 16-bit address.
// - index advances after each completed table-location access through the data register.
// - index ignored for single-location sets.
// - set low bit carries read or write command into table pipeline.
// - 24-bit registers move as red, green, blue bytes.
// - component counter returns to red on set or index write.
// - unused bits of narrow registers always read as zero.
// - sets 0/1 true-colour write/read, 2/3 pseudo, 256 entries each.
// - sets 32/33 write/read four-entry overlay table.
// - single-location control registers at sets 64,67,70,73,74,75.
// - sets 128-130 read checksum low, middle, high bytes.
// - table load commits entry and advances index every third byte.
// - table entries update only as a complete triple.
// - table reads return red, green, blue, index advances per triple.
// - vertical sync clears the three checksum bytes.
`timescale 1ns/1ps
module palette_host_register_port
	import palette_pkg::*;
#(
	parameter int ENTRIES = TABLE_ENTRIES,
	parameter int OVL     = OVERLAY_ENTRIES
)(
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        write_strobe_n,
	input  wire logic        read_strobe_n,
	input  wire logic [1:0]  register_select,
	input  wire logic [7:0]  host_data_bus_in,
	output logic      [7:0]  host_data_bus_out,
	output logic             host_data_bus_oe,
	input  wire logic        vsync_n,
	input  wire logic        csum_update,
	input  wire logic [23:0] csum_value,
	output logic      [15:0] internal_address,
	output logic             table_write_cmd,
	output logic      [7:0]  pseudo_mask,
	output logic      [1:0]  overlay_mask,
	output logic      [4:0]  dac_control,
	output logic      [6:0]  pixel_mode,
	output logic      [3:0]  panning,
	output logic      [1:0]  compositing
);
	strobe_ev_type ev;
	logic [1:0]  sel_s;
	logic [7:0]  dat_s;
	logic        vs_low;
	logic [7:0]  set_r;
	logic [7:0]  index_r;
	logic [1:0]  wsel_r;
	logic [1:0]  rsel_r;
	comp_type    comp_r;
	logic [7:0]  red_r;
	logic [7:0]  green_r;
	logic [23:0] csum_r;
	logic [7:0]  rd_byte;
	colour_type  rd_entry;
	colour_type  true_tab [ENTRIES];
	colour_type  pseu_tab [ENTRIES];
	colour_type  ovl_tab  [OVL];
	logic        data_wr;
	logic        data_rd_done;
	logic        commit;
	logic        triple_end;

	strobe_sync u_sync (
		.clock           (clock),
		.sys_rst         (sys_rst),
		.write_strobe_n  (write_strobe_n),
		.read_strobe_n   (read_strobe_n),
		.vsync_n         (vsync_n),
		.register_select (register_select),
		.data_in         (host_data_bus_in),
		.events          (ev),
		.select_sync     (sel_s),
		.data_sync       (dat_s),
		.vsync_low       (vs_low)
	);

	// true when a set code names a colour or overlay table
	function automatic logic is_table(input logic [7:0] s);
		is_table = (s[7:2] == 6'h00) || (s[7:1] == SET_OVL_WR[7:1]);
	endfunction

	// selects latched at falling edge of write strobe
	always_ff @(posedge clock) begin
		if (sys_rst)
			wsel_r <= SEL_SET;
		else if (ev.wr_fall)
			wsel_r <= sel_s;
	end

	// selects latched at falling edge of read strobe
	always_ff @(posedge clock) begin
		if (sys_rst)
			rsel_r <= SEL_SET;
		else if (ev.rd_fall)
			rsel_r <= sel_s;
	end

	// latched select decides the access target
	assign data_wr = ev.wr_rise && (wsel_r == SEL_DATA);
	assign data_rd_done = ev.rd_rise && (rsel_r == SEL_DATA);
	assign triple_end = (comp_r == COMP_BLUE);
	// commit only when the blue byte completes a write triple
	assign commit = data_wr && triple_end && is_table(set_r)
		&& !set_r[0];

	// set register written through select 0
	always_ff @(posedge clock) begin
		if (sys_rst)
			set_r <= RESET_BYTE;
		else if (ev.wr_rise && wsel_r == SEL_SET)
			set_r <= dat_s;
	end

	// index written by host or stepped after a whole location
	always_ff @(posedge clock) begin
		if (sys_rst)
			index_r <= RESET_BYTE;
		else if (ev.wr_rise && wsel_r == SEL_INDEX)
			index_r <= dat_s;
		// advance after each third byte written
		else if (data_wr && triple_end && is_table(set_r))
			index_r <= index_r + 8'h01;
		// advance after each third byte read
		else if (data_rd_done && triple_end && is_table(set_r))
			index_r <= index_r + 8'h01;
	end

	// counter back to red on set or index write
	always_ff @(posedge clock) begin
		if (sys_rst)
			comp_r <= COMP_RED;
		else if (ev.wr_rise && (wsel_r == SEL_SET || wsel_r == SEL_INDEX))
			comp_r <= COMP_RED;
		// step red, green, blue on table data bytes
		else if ((data_wr || data_rd_done) && is_table(set_r)) begin
			unique case (comp_r)
				COMP_RED:   comp_r <= COMP_GREEN;
				COMP_GREEN: comp_r <= COMP_BLUE;
				COMP_BLUE:  comp_r <= COMP_RED;
				default:    comp_r <= COMP_RED;
			endcase
		end
	end

	// holding registers for red and green until blue arrives
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			red_r <= RESET_BYTE;
			green_r <= RESET_BYTE;
		end else if (data_wr && comp_r == COMP_RED) begin
			red_r <= dat_s;
		end else if (data_wr && comp_r == COMP_GREEN) begin
			green_r <= dat_s;
		end
	end

	// true-colour and pseudo tables, written on set 0 and 2
	always_ff @(posedge clock) begin
		if (commit && set_r == SET_TRUE_WR)
			true_tab[index_r] <= '{red_r, green_r, dat_s};
		if (commit && set_r == SET_PSEU_WR)
			pseu_tab[index_r] <= '{red_r, green_r, dat_s};
	end

	// overlay table written on set 32, index low bits only
	always_ff @(posedge clock) begin
		if (commit && set_r == SET_OVL_WR)
			ovl_tab[index_r[1:0]] <= '{red_r, green_r, dat_s};
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pseudo_mask <= RESET_BYTE;
			overlay_mask <= 2'h0;
			dac_control <= 5'h00;
			pixel_mode <= 7'h00;
			panning <= 4'h0;
			compositing <= 2'h0;
		end else if (data_wr) begin
			// reserved sets fall through, nothing stored
			unique case (set_r)
				SET_PMASK:   pseudo_mask <= dat_s & MASK_PMASK;
				SET_OMASK:   overlay_mask <= dat_s[1:0];
				SET_DACCTL:  dac_control <= dat_s[4:0];
				SET_PIXMODE: pixel_mode <= dat_s[6:0];
				SET_PAN:     panning <= dat_s[3:0];
				SET_COMPOS:  compositing <= dat_s[1:0];
				default:     ;
			endcase
		end
	end

	// checksum cleared by vertical sync, else sampled
	always_ff @(posedge clock) begin
		if (sys_rst || vs_low)
			csum_r <= 24'h000000;
		else if (csum_update)
			csum_r <= csum_value;
	end

	// set and index together form the internal address
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			internal_address <= 16'h0000;
			table_write_cmd <= 1'b0;
		end else begin
			internal_address <= {set_r, index_r};
			// set low bit passes read or write to the pipeline
			table_write_cmd <= is_table(set_r) && !set_r[0];
		end
	end

	// table entry selected for reads
	always_comb begin
		unique case (set_r)
			SET_TRUE_RD: rd_entry = true_tab[index_r];
			SET_PSEU_RD: rd_entry = pseu_tab[index_r];
			SET_OVL_RD:  rd_entry = ovl_tab[index_r[1:0]];
			default:     rd_entry = '0;
		endcase
	end

	// read data mux; narrow fields zero-extended
	always_comb begin
		rd_byte = 8'h00;
		unique case (rsel_r)
			SEL_SET:   rd_byte = set_r;
			SEL_INDEX: rd_byte = index_r;
			SEL_DATA: begin
				// write-only sets and reserved ones read zero
				unique case (set_r)
					SET_TRUE_RD, SET_PSEU_RD, SET_OVL_RD:
						rd_byte = (comp_r == COMP_RED) ? rd_entry.red :
							(comp_r == COMP_GREEN) ? rd_entry.green :
							rd_entry.blue;
					SET_PMASK:    rd_byte = pseudo_mask;
					SET_OMASK:    rd_byte = {6'h00, overlay_mask};
					SET_DACCTL:   rd_byte = {3'h0, dac_control};
					SET_PIXMODE:  rd_byte = {1'b0, pixel_mode};
					SET_PAN:      rd_byte = {4'h0, panning};
					SET_COMPOS:   rd_byte = {6'h00, compositing};
					SET_CSUM_LO:  rd_byte = csum_r[7:0];
					SET_CSUM_MID: rd_byte = csum_r[15:8];
					SET_CSUM_HI:  rd_byte = csum_r[23:16];
					default:      rd_byte = 8'h00;
				endcase
			end
			default:   rd_byte = 8'h00;
		endcase
	end

	// bus driven only while the read strobe is low
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			host_data_bus_oe <= 1'b0;
			host_data_bus_out <= 8'h00;
		end else begin
			if (ev.rd_fall)
				host_data_bus_oe <= 1'b1;
			else if (ev.rd_rise)
				host_data_bus_oe <= 1'b0;
			// refreshed each cycle so the latched select is seen
			host_data_bus_out <= rd_byte;
		end
	end

	// bus not driven in the cycle after a write strobe fall event
	property p_no_drive_on_write;
		@(posedge clock) disable iff (sys_rst)
		ev.wr_fall |=> !host_data_bus_oe;
	endproperty
	a_no_drive_on_write: assert property (p_no_drive_on_write)
		else $error("bus driven during write");

	property p_oe_release;
		@(posedge clock) disable iff (sys_rst)
		ev.rd_rise |=> !host_data_bus_oe;
	endproperty
	a_oe_release: assert property (p_oe_release)
		else $error("bus not released after read");

	property p_oe_on;
		@(posedge clock) disable iff (sys_rst)
		ev.rd_fall |=> host_data_bus_oe;
	endproperty
	a_oe_on: assert property (p_oe_on)
		else $error("bus not driven on read");

	property p_comp_reset;
		@(posedge clock) disable iff (sys_rst)
		ev.wr_rise && (wsel_r == SEL_SET || wsel_r == SEL_INDEX)
		|=> comp_r == COMP_RED;
	endproperty
	a_comp_reset: assert property (p_comp_reset)
		else $error("component counter not reset");

	property p_index_step;
		@(posedge clock) disable iff (sys_rst)
		data_wr && triple_end && is_table(set_r)
		|=> index_r == $past(index_r) + 8'h01;
	endproperty
	a_index_step: assert property (p_index_step)
		else $error("index did not advance");

	property p_set_load;
		@(posedge clock) disable iff (sys_rst)
		ev.wr_rise && wsel_r == SEL_SET |=> set_r == $past(dat_s);
	endproperty
	a_set_load: assert property (p_set_load)
		else $error("set register not loaded");

	property p_csum_clear;
		@(posedge clock) disable iff (sys_rst)
		vs_low |=> csum_r == 24'h000000;
	endproperty
	a_csum_clear: assert property (p_csum_clear)
		else $error("checksum not cleared");

	property p_narrow_zero;
		@(posedge clock) disable iff (sys_rst)
		rsel_r == SEL_DATA && set_r == SET_OMASK
		|=> host_data_bus_out[7:2] == 6'h00;
	endproperty
	a_narrow_zero: assert property (p_narrow_zero)
		else $error("reserved bits not zero");
endmodule

// >>> tb/host_model.sv
// host processor model: strobes, selects and the shared data bus
`timescale 1ns/1ps
module host_model (
	input  wire logic       clock,
	input  wire logic [7:0] host_data_bus_out,
	input  wire logic       host_data_bus_oe,
	output logic            write_strobe_n,
	output logic            read_strobe_n,
	output logic [1:0]      register_select,
	output logic [7:0]      host_data_bus_in,
	output logic            rd_valid,
	output logic [7:0]      rd_byte
);
	logic       drv;
	logic [7:0] dat;
	logic [7:0] last_r;
	initial begin
		write_strobe_n = 1'b1;
		read_strobe_n = 1'b1;
		register_select = 2'h0;
		drv = 1'b0;
		dat = 8'h00;
		rd_valid = 1'b0;
		rd_byte = 8'h00;
		last_r = 8'h00;
	end
	// one shared bus
	// released bus flips each cycle so a stale byte never passes
	always_comb begin
		if (drv)
			host_data_bus_in = dat;
		else if (host_data_bus_oe)
			host_data_bus_in = host_data_bus_out;
		else
			host_data_bus_in = ~last_r;
	end
	// last pin level, feeds the idle pattern
	always @(posedge clock) last_r <= host_data_bus_in;
	// write cycle
	// select and data held well past the sync depth
	task automatic wr(input logic [1:0] s, input logic [7:0] d);
		@(posedge clock) #1;
		register_select = s;
		dat = d;
		drv = 1'b1;
		repeat (4) @(posedge clock);
		#1 write_strobe_n = 1'b0;
		repeat (6) @(posedge clock);
		#1 write_strobe_n = 1'b1;
		repeat (3) @(posedge clock);
		#1 drv = 1'b0;
		repeat (4) @(posedge clock);
	endtask
	task automatic rd(input logic [1:0] s);
		@(posedge clock) #1;
		register_select = s;
		repeat (4) @(posedge clock);
		#1 read_strobe_n = 1'b0;
		repeat (7) @(posedge clock);
		rd_byte = host_data_bus_in;
		#1 read_strobe_n = 1'b1;
		rd_valid = 1'b1;
		@(posedge clock) #1 rd_valid = 1'b0;
		repeat (6) @(posedge clock);
	endtask
endmodule

// >>> tb/tb_palette_host_register_port.sv
// self-checking bench for the palette host register port
`timescale 1ns/1ps
module tb_palette_host_register_port;
	import palette_pkg::*;
	logic        clock = 1'b0;
	logic        sys_rst = 1'b1;
	logic        vsync_n = 1'b1;
	logic        csum_update = 1'b0;
	logic [23:0] csum_value = 24'h000000;
	logic        wr_n, rd_n, oe, cmd;
	logic [1:0]  sel, om, cm;
	logic [7:0]  din, dout, pm;
	logic [4:0]  dc;
	logic [6:0]  px;
	logic [3:0]  pn;
	logic [15:0] ia;
	logic [7:0]  q[$];
	logic [31:0] rnd = 32'h30E8;
	colour_type  ent[2];
	int          miscompares = 0;
	int          n_compared = 0;
	int          cycles = 0;
	logic [7:0]  sets[6] = '{8'h40, 8'h43, 8'h46, 8'h49, 8'h4A, 8'h4B};
	logic [7:0]  msk[6] = '{8'hFF, 8'h03, 8'h1F, 8'h7F, 8'h0F, 8'h03};
	logic [7:0]  v[6];
	logic [7:0]  ws[3] = '{8'h00, 8'h02, 8'h20};
	logic [7:0]  st[3] = '{8'hFE, 8'h07, 8'h02};
	logic [7:0]  nx[3] = '{8'h00, 8'h09, 8'h04};
	// 10 ns clock
	always #5 clock = ~clock;
	palette_host_register_port uut (
		.clock(clock), .sys_rst(sys_rst), .write_strobe_n(wr_n),
		.read_strobe_n(rd_n), .register_select(sel),
		.host_data_bus_in(din), .host_data_bus_out(dout),
		.host_data_bus_oe(oe), .vsync_n(vsync_n),
		.csum_update(csum_update), .csum_value(csum_value),
		.internal_address(ia), .table_write_cmd(cmd),
		.pseudo_mask(pm), .overlay_mask(om), .dac_control(dc),
		.pixel_mode(px), .panning(pn), .compositing(cm));
	host_model host (
		.clock(clock), .host_data_bus_out(dout),
		.host_data_bus_oe(oe), .write_strobe_n(wr_n),
		.read_strobe_n(rd_n), .register_select(sel),
		.host_data_bus_in(din), .rd_valid(), .rd_byte());
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic finish_test();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// note expected byte, then read it
	task automatic rdx(input logic [1:0] s, input logic [7:0] e);
		q.push_back(e);
		host.rd(s);
	endtask
	// set, index, then two whole colour triples
	task automatic load(input logic [7:0] s, input logic [7:0] i);
		logic [23:0] c;
		host.wr(SEL_SET, s);
		host.wr(SEL_INDEX, i);
		for (int k = 0; k < 2; k++) begin
			c = ent[k];
			for (int b = 0; b < 3; b++)
				host.wr(SEL_DATA, c[23-8*b -: 8]);
		end
	endtask
	task automatic fetch(input logic [7:0] s, input logic [7:0] i,
			input int n);
		logic [23:0] c;
		host.wr(SEL_SET, s);
		host.wr(SEL_INDEX, i);
		for (int k = 0; k < n; k++) begin
			c = ent[k];
			for (int b = 0; b < 3; b++)
				rdx(SEL_DATA, c[23-8*b -: 8]);
		end
	endtask
	// result watcher: oldest note against each read
	always @(posedge clock) begin
		if (host.rd_valid === 1'b1) begin
			if (q.size() == 0) begin
				miscompares++;
				$display("[FAIL] t=%0t got=%h exp=%h", $time, host.rd_byte, 0);
			end else
				cmp_byte(host.rd_byte, q.pop_front());
		end
	end
	// cycle ceiling, far above the few thousand cycles needed
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			finish_test();
		end
	end
	initial begin
		repeat (12) @(posedge clock);
		#1 sys_rst = 1'b0;
		repeat (4) @(posedge clock);
		chk({oe, 3'h0, pm, om, dc, px, pn, cm}, 32'h0);
		// control registers, unused bits written as ones
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			v[i] = rnd[7:0] | ~msk[i];
			host.wr(SEL_SET, sets[i]);
			host.wr(SEL_INDEX, rnd[15:8]);
			host.wr(SEL_DATA, v[i]);
			rdx(SEL_DATA, v[i] & msk[i]);
			rdx(SEL_DATA, v[i] & msk[i]);
			rdx(SEL_SET, sets[i]);
		end
		// a well-behaved host keeps unused bits at zero
		host.wr(SEL_SET, SET_DACCTL);
		host.wr(SEL_DATA, v[2] & msk[2]);
		rdx(SEL_DATA, v[2] & msk[2]);
		// three tables, two entries each, true-colour index wraps at the top
		for (int t = 0; t < 3; t++) begin
			rnd = lfsr(rnd);
			ent[0] = rnd[23:0];
			rnd = lfsr(rnd);
			ent[1] = rnd[31:8];
			load(ws[t], st[t]);
			host.wr(SEL_INDEX, st[t]);
			chk({cmd, ia}, {1'b1, ws[t], st[t]});
			fetch(ws[t] | 8'h01, st[t], 2);
			chk({cmd, ia}, {1'b0, ws[t] | 8'h01, nx[t]});
			rdx(SEL_INDEX, nx[t]);
		end
		// half a triple must not land; set write restarts at red
		load(SET_TRUE_WR, 8'h09);
		host.wr(SEL_INDEX, 8'h09);
		host.wr(SEL_DATA, 8'hA5);
		host.wr(SEL_DATA, 8'h5A);
		fetch(SET_TRUE_RD, 8'h09, 1);
		// reserved code, reserved set, wrong-direction sets
		host.wr(2'h3, 8'hA5);
		rdx(2'h3, 8'h00);
		host.wr(SEL_SET, 8'h05);
		host.wr(SEL_DATA, 8'h5A);
		rdx(SEL_DATA, 8'h00);
		host.wr(SEL_SET, SET_TRUE_WR);
		rdx(SEL_DATA, 8'h00);
		host.wr(SEL_SET, SET_TRUE_RD);
		host.wr(SEL_INDEX, 8'h09);
		for (int b = 0; b < 3; b++)
			host.wr(SEL_DATA, 8'hC3);
		fetch(SET_TRUE_RD, 8'h09, 1);
		chk({pm, 2'h0, om, 3'h0, dc}, {v[0], 2'h0, v[1][1:0], 3'h0,
			v[2][4:0]});
		chk({px, pn, cm}, {v[3][6:0], v[4][3:0], v[5][1:0]});
		// checksum load, read-only bytes, then vertical sync clear
		rnd = lfsr(rnd);
		@(posedge clock) #1;
		csum_value = rnd[23:0];
		csum_update = 1'b1;
		@(posedge clock) #1 csum_update = 1'b0;
		host.wr(SEL_SET, SET_CSUM_LO);
		host.wr(SEL_DATA, ~rnd[7:0]);
		for (int k = 0; k < 3; k++) begin
			host.wr(SEL_SET, SET_CSUM_LO + k[7:0]);
			rdx(SEL_DATA, csum_value[8*k +: 8]);
		end
		@(posedge clock) #1 vsync_n = 1'b0;
		repeat (6) @(posedge clock);
		#1 vsync_n = 1'b1;
		for (int k = 0; k < 3; k++) begin
			host.wr(SEL_SET, SET_CSUM_LO + k[7:0]);
			rdx(SEL_DATA, 8'h00);
		end
		repeat (10) @(posedge clock);
		if (q.size() != 0)
			miscompares++;
		finish_test();
	end
endmodule
